// ---- strap_led_pkg.sv ----
// Purpose: shared constants and types for the strap/led pin block
// Assumes: five shared pins, bit index = pin number
// Notes: none
package strap_led_pkg;
   localparam int NUM_PINS = 5;
   localparam logic [4:0] ADDR_ISOLATE = 5'h00;
   localparam logic [4:0] ADDR_RST_VAL = 5'h00;
   localparam logic [4:0] OE_ALL_IN = 5'h00;
   localparam logic [4:0] OE_ALL_OUT = 5'h1f;
   localparam int PIN_ACT = 0;
   localparam int PIN_COL = 1;
   localparam int PIN_LINK = 2;
   localparam int PIN_TX = 3;
   localparam int PIN_RX = 4;

   // raw status events from the phy core
   typedef struct packed {
      logic rx_active;
      logic tx_active;
      logic link_ok;
      logic full_duplex;
   } core_status_t;

   // three signals per shared pin
   typedef struct packed {
      logic [4:0] pin_in;
      logic [4:0] pin_out;
      logic [4:0] pin_oe;
   } strap_pins_t;

   typedef enum logic [2:0] {
      ST_STRAP = 3'b001,
      ST_CAPTURE = 3'b010,
      ST_LED = 3'b100
   } pin_mode_t;
endpackage

// ---- link_status_led_strap_pins.sv ----
// Purpose: shared strap inputs / status led outputs of a phy
// Assumes: i_hw_reset covers power-on and hardware reset; pins pulled by board
// Notes: i_rst initialises state; capture happens on release of i_rst and on release of i_hw_reset
`timescale 1ns/100ps

module link_status_led_strap_pins
   import strap_led_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // reset requests
   input wire logic i_hw_reset,
   input wire logic i_sw_reset,
   // phy core status
   input wire core_status_t i_status,
   // shared pins
   input wire logic [4:0] i_pin,
   output logic [4:0] o_pin,
   output logic [4:0] o_pin_oe,
   // results
   output logic [4:0] o_phy_addr,
   output logic o_mac_outputs_en
);
   logic [4:0] pin_s1_r;
   logic [4:0] pin_s2_r;
   logic hw_s1_r;
   logic hw_s2_r;
   pin_mode_t mode_r;
   logic [4:0] addr_r;
   logic [4:0] led_on;
   logic [4:0] pin_out_r;
   logic [4:0] pin_oe_r;
   logic mac_en_r;

   // two flops on the pins and the hw reset: both come from outside this clock

   always_ff @(posedge i_sys_clk)
   begin
      pin_s1_r <= i_pin;
      pin_s2_r <= pin_s1_r;
      hw_s1_r <= i_hw_reset;
      hw_s2_r <= hw_s1_r;
   end

   // output after capture
   // a synced hw reset always returns the pins to inputs
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         mode_r <= ST_STRAP;
      else if (hw_s2_r)
         mode_r <= ST_STRAP;
      else
      begin
         unique case (mode_r)
            ST_STRAP: mode_r <= ST_CAPTURE;
            ST_CAPTURE: mode_r <= ST_LED;
            ST_LED: mode_r <= ST_LED;
            default: mode_r <= ST_STRAP;
         endcase
      end
   end

   // levels become address
   // capture reads the second flop only, so the level is settled
   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         addr_r <= ADDR_RST_VAL;
      else if (mode_r == ST_CAPTURE)
         addr_r <= pin_s2_r;
   end

   addr_capture_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      mode_r == ST_CAPTURE |=> o_phy_addr == $past(pin_s2_r))
      else $error("address not captured");

   addr_exit_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $fell(hw_s2_r) |-> ##2 o_phy_addr == $past(pin_s2_r))
      else $error("address not loaded at reset exit");

   addr_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      mode_r != ST_CAPTURE |=> $stable(o_phy_addr))
      else $error("address changed outside capture");

   sw_addr_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sw_reset && !hw_s2_r && mode_r == ST_LED) |=> $stable(o_phy_addr))
      else $error("sw reset changed address");

   always_comb
   begin
      led_on = '0;
      led_on[PIN_ACT] = i_status.rx_active | i_status.tx_active;
      led_on[PIN_COL] = ~i_status.full_duplex & i_status.rx_active & i_status.tx_active;
      led_on[PIN_LINK] = i_status.link_ok;
      led_on[PIN_TX] = i_status.tx_active;
      led_on[PIN_RX] = i_status.rx_active;
   end

   col_full_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      i_status.full_duplex |-> !led_on[PIN_COL])
      else $error("collision in full duplex");

   col_half_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (!i_status.full_duplex && i_status.rx_active && i_status.tx_active) |-> led_on[PIN_COL])
      else $error("collision missed in half duplex");

   led_map_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      led_on[PIN_TX] == i_status.tx_active && led_on[PIN_RX] == i_status.rx_active)
      else $error("led map");

   act_link_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      led_on[PIN_ACT] == (i_status.rx_active | i_status.tx_active) && led_on[PIN_LINK] == i_status.link_ok)
      else $error("activity or link led wrong");

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
      begin
         pin_out_r <= '0;
         pin_oe_r <= '0;
      end
      else
      begin
         pin_out_r <= led_on ^ addr_r;
         // release the pins on the first synced reset edge, not one later
         pin_oe_r <= (mode_r == ST_LED && !hw_s2_r) ? OE_ALL_OUT : OE_ALL_IN;
      end
   end

   pin_input_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      hw_s2_r |=> o_pin_oe == OE_ALL_IN)
      else $error("pins driven during reset");

   oe_strap_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      mode_r != ST_LED |=> o_pin_oe == OE_ALL_IN)
      else $error("pins driven before capture");

   pin_output_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      $fell(hw_s2_r) |-> ##3 o_pin_oe == OE_ALL_OUT)
      else $error("pins not outputs after capture");

   oe_whole_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      o_pin_oe == OE_ALL_IN || o_pin_oe == OE_ALL_OUT)
      else $error("pins switched apart");

   sw_reset_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (i_sw_reset && !hw_s2_r && mode_r == ST_LED) |=> o_pin_oe == OE_ALL_OUT)
      else $error("sw reset changed pins");

   // led mode left only by hw reset
   mode_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (mode_r == ST_LED && !hw_s2_r) |=> mode_r == ST_LED)
      else $error("led mode left without hw reset");

   led_polarity_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      1'b1 |=> o_pin == ($past(led_on) ^ $past(addr_r)))
      else $error("led polarity wrong");

   always_ff @(posedge i_sys_clk)
   begin
      if (i_rst)
         mac_en_r <= 1'b0;
      else
         // keep the mac side isolated while a hw reset is seen
         mac_en_r <= (mode_r == ST_LED) && !hw_s2_r && (addr_r != ADDR_ISOLATE);
   end

   mac_isolate_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (mode_r == ST_LED && addr_r == ADDR_ISOLATE) |=> !o_mac_outputs_en)
      else $error("mac not isolated");

   mac_enable_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      (mode_r == ST_LED && !hw_s2_r && addr_r != ADDR_ISOLATE) |=> o_mac_outputs_en)
      else $error("mac not enabled");

   hw_entry_mac_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
      hw_s2_r |=> !o_mac_outputs_en)
      else $error("mac enabled during reset");

   assign o_pin = pin_out_r;
   assign o_pin_oe = pin_oe_r;
   assign o_phy_addr = addr_r;
   assign o_mac_outputs_en = mac_en_r;

   // main scenarios reached
   strap_exit_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) $fell(hw_s2_r) ##3 o_pin_oe == 5'h1f);
   isolate_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) mode_r == ST_LED && !o_mac_outputs_en);
   collision_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) led_on[PIN_COL]);
   sw_reset_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) i_sw_reset && mode_r == ST_LED);
   hw_reenter_c: cover property (@(posedge i_sys_clk) disable iff (i_rst) mode_r == ST_LED ##1 hw_s2_r);
endmodule // link_status_led_strap_pins

// ---- strap_board_model.sv ----
// Purpose: board pull resistors and leds on the five shared pins
// Assumes: every pin is pulled one way, none floats
// Notes: pull pattern is chosen by the bench
`timescale 1ns/100ps
module strap_board_model
(
   // pin side
   input wire logic [4:0] i_pull,
   input wire logic [4:0] i_drv,
   input wire logic [4:0] i_drv_oe,
   output logic [4:0] o_level
);
   always_comb
   begin
      for (int k = 0; k < 5; k++)
      begin
         o_level[k] = i_drv_oe[k] ? i_drv[k] : i_pull[k];
      end
   end
endmodule // strap_board_model

// ---- link_status_led_strap_pins_tb_top.sv ----
// Purpose: self-checking bench for the strap/led pins
// Assumes: 50 ns clock, board model on the pins
// Notes: no random stimulus
`timescale 1ns/100ps
module link_status_led_strap_pins_tb_top;
   import strap_led_pkg::*;
   logic i_sys_clk = 0, i_rst = 1, i_hw_reset = 0, i_sw_reset = 0, o_mac_outputs_en;
   core_status_t i_status = '0;
   logic [4:0] pull = 5'h00, lvl, o_pin, o_pin_oe, o_phy_addr, a;
   int fail_count = 0, check_count = 0, cyc = 0;
   initial forever #25 i_sys_clk = ~i_sys_clk;
   strap_board_model strap_board_model_i (.i_pull(pull), .i_drv(o_pin), .i_drv_oe(o_pin_oe), .o_level(lvl));
   link_status_led_strap_pins link_status_led_strap_pins_i (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
      .i_hw_reset(i_hw_reset), .i_sw_reset(i_sw_reset), .i_status(i_status), .i_pin(lvl), .o_pin(o_pin),
      .o_pin_oe(o_pin_oe), .o_phy_addr(o_phy_addr), .o_mac_outputs_en(o_mac_outputs_en));
   task automatic chk(string n, logic [4:0] seen, logic [4:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s exp %h seen %h", n, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic hw_cycle(logic [4:0] v);
      @(posedge i_sys_clk);
      a = v;
      pull <= v;
      i_hw_reset <= 1;
      tick(5);
      chk("oe_in_reset", o_pin_oe, 5'h00);
      @(posedge i_sys_clk);
      i_hw_reset <= 0;
      tick(8);
      pull <= ~v;
      tick(4);
      chk("addr", o_phy_addr, v);
      chk("oe", o_pin_oe, 5'h1f);
      chk("mac_en", {4'h0, o_mac_outputs_en}, {4'h0, v != ADDR_ISOLATE});
   endtask
   task automatic led_scn;
      @(posedge i_sys_clk);
      i_status <= '{rx_active: 1, tx_active: 1, link_ok: 1, full_duplex: 0};
      tick(3);
      chk("led_all", o_pin, ~a);
      @(posedge i_sys_clk);
      i_status.full_duplex <= 1;
      tick(3);
      chk("led_fdx", o_pin, ~a ^ 5'h02);
      @(posedge i_sys_clk);
      i_status <= '0;
      tick(3);
      chk("led_off", o_pin, a);
   endtask
   task automatic sw_scn;
      @(posedge i_sys_clk);
      i_sw_reset <= 1;
      tick(6);
      chk("sw_oe", o_pin_oe, 5'h1f);
      chk("sw_addr", o_phy_addr, a);
      chk("sw_mac", {4'h0, o_mac_outputs_en}, {4'h0, a != ADDR_ISOLATE});
      @(posedge i_sys_clk);
      i_sw_reset <= 0;
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge i_sys_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fail_count++;
         end_of_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge i_sys_clk);
      i_rst <= 0;
      hw_cycle(5'h00);
      hw_cycle(5'h15);
      led_scn();
      sw_scn();
      hw_cycle(5'h0a);
      led_scn();
      end_of_test();
   end
endmodule // link_status_led_strap_pins_tb_top
